/* File: design/dmem_map.svh */
// address, field and timing constants for the data memory map block
//----------------------------------------------------------------------
// Operation
// - two 16-bit pointers, bit 0 selects one
// - flag bit 2 ignores writes, reads zero
// - pointer instructions use the selected pointer
// - increment adds one to selected pointer
// - load writes 16-bit constant to selected pointer
// - pointer low, high bytes individually accessible
// - lower RAM reachable direct and indirect
// - upper RAM indirect only, separate storage
// - direct above 7Fh goes to registers
// - indirect above 7Fh goes to upper RAM
// - select clear: moves below 200h use onchip RAM
// - onchip RAM leaves port 0, strobes idle
// - select clear: pointer moves above 1FFh external
// - select set: register move, 8-bit muxed address
// - select set: pointer move, 16-bit address
// - external move pulses write or read strobe
// - stack uses only 256-byte internal RAM
//----------------------------------------------------------------------
`ifndef DMEM_MAP_SVH
`define DMEM_MAP_SVH

// special function register addresses
`define DM_SFR_PTR_LO   8'h82
`define DM_SFR_PTR_HI   8'h83
`define DM_SFR_AUX      8'h8e
`define DM_SFR_AUX1     8'ha2

// field positions
`define DM_BIT_PSEL     0
`define DM_BIT_UFLAG    2
`define DM_BIT_EXTERNAL_RAM_SELECT   1
`define DM_BIT_ALEOFF   0

// address boundaries
`define DM_LOWER_TOP    8'h7f
`define DM_EXPANDED_ONCHIP_RAM_TOP     16'h01ff

// reset values and timing counts
`define DM_RST_BYTE     8'h00
`define DM_RST_WORD     16'h0000
`define DM_ADDR_CYC     4'h2
`define DM_STROBE_CYC   4'h3
`define DM_ALE_DIV      3'h6

`endif

/* File: design/dmem_pkg.sv */
// types shared by the data memory map block
`default_nettype none
package dmem_pkg;
    // external move sequencer phases
    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_EXPANDED_ONCHIP_RAM,
        BUS_ADDR,
        BUS_STROBE
    } busState_t;
endpackage
`default_nettype wire

/* File: design/dmem_ram.sv */
// single port byte memory with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "dmem_map.svh"
module dmem_ram
#(
    parameter int DEPTH = 256,
    parameter int AW    = 8
)
(
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    input  wire logic          we,
    input  wire logic          re,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output var  logic [7:0]    rdata
);
    logic [7:0] mem [DEPTH];

    if (DEPTH > (1 << AW))
    begin : g_chk
        $error("dmem_ram: depth exceeds address width");
    end

    // storage write
    always_ff @(posedge ref_clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
    end

    // registered read port
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= `DM_RST_BYTE;
        end
        else if (re)
        begin
            rdata <= mem[addr];
        end
    end
endmodule
`default_nettype wire

/* File: design/data_ptr_pair.sv */
// two 16-bit data pointers with selectable active one
`timescale 1ns/10ps
`default_nettype none
`include "dmem_map.svh"
module data_ptr_pair
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        pointerSelectBit,
    input  wire logic        incEn,
    input  wire logic        loadEn,
    input  wire logic [15:0] loadVal,
    input  wire logic        wrLo,
    input  wire logic        wrHi,
    input  wire logic [7:0]  byteData,
    output var  logic [15:0] curPtr
);
    logic [15:0] ptr_ff [2];

    assign curPtr = ptr_ff[pointerSelectBit];

    // updates hit only the selected pointer
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ptr_ff[0] <= `DM_RST_WORD;
            ptr_ff[1] <= `DM_RST_WORD;
        end
        else if (loadEn)
        begin
            ptr_ff[pointerSelectBit] <= loadVal;
        end
        else if (incEn)
        begin
            ptr_ff[pointerSelectBit] <= curPtr + 16'h0001;
        end
        else if (wrLo)
        begin
            ptr_ff[pointerSelectBit][7:0] <= byteData;
        end
        else if (wrHi)
        begin
            ptr_ff[pointerSelectBit][15:8] <= byteData;
        end
    end
endmodule
`default_nettype wire

/* File: design/dmem_map_core.sv */
// data memory address decode, dual pointers and external move sequencer
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "dmem_map.svh"
module dmem_map_core
#(
    parameter int IRAM_DEPTH = 256,
    parameter int EXPANDED_ONCHIP_RAM_DEPTH = 512
)
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // direct addressing port (registers above lower RAM)
    input  wire logic [7:0]        dirAddr,
    input  wire logic [7:0]        dirWdata,
    input  wire logic              dirWr,
    input  wire logic              dirRd,
    output var  logic [7:0]        dirRdata,
    // indirect addressing port, stack included
    input  wire logic [7:0]        indAddr,
    input  wire logic [7:0]        indWdata,
    input  wire logic              indWr,
    input  wire logic              indRd,
    output var  logic [7:0]        indRdata,
    // pointer instructions
    input  wire logic              ptrInc,
    input  wire logic              ptrLoad,
    input  wire logic [15:0]       ptrImm,
    output var  logic [15:0]       ptrValue,
    // external move requests
    input  wire logic              movxReq,
    input  wire logic              movxWrite,
    input  wire logic              movxUsePtr,
    input  wire logic [7:0]        movxRiAddr,
    input  wire logic [7:0]        movxWdata,
    output var  logic              movxBusy,
    output var  logic              movxDone,
    output var  logic [7:0]        movxRdata,
    // external bus pins
    input  wire logic [7:0]        p0In,
    output var  logic [7:0]        p0Out,
    output var  logic              p0Oe,
    output var  logic [7:0]        p2Out,
    output var  logic              p2Oe,
    output var  logic              wrStrobeN,
    output var  logic              rdStrobeN,
    output var  logic              aleOut,
    output var dmem_pkg::busState_t busPhase
);
    import dmem_pkg::*;

    //------------------------------------------------------------------
    // elaboration checks
    //------------------------------------------------------------------
    if (IRAM_DEPTH != 256 || EXPANDED_ONCHIP_RAM_DEPTH != 512)
    begin : g_chk
        $error("dmem_map_core: decode serves 256/512 byte memories only");
    end

    //------------------------------------------------------------------
    // declarations
    //------------------------------------------------------------------
    logic        pointerSelectBit_ff;
    logic        externalRamSelect_ff;
    logic        aleOff_ff;
    logic [7:0]  sfrRd_ff;
    logic        dirFromRam_ff;
    logic [15:0] curPtr;
    logic        dirLower;
    logic        sfrWr;
    logic        iramWe;
    logic        iramRe;
    logic [7:0]  iramAddr;
    logic [7:0]  iramWdata;
    logic [7:0]  iramQ;
    logic        xramWe;
    logic        xramRe;
    logic [8:0]  xramAddr;
    logic [7:0]  xramQ;
    logic        toXram;
    logic        startMove;
    logic [15:0] moveAddr;
    logic        write_ff;
    logic        usePtr_ff;
    logic [7:0]  wdata_ff;
    logic [3:0]  cnt_ff;
    logic [2:0]  aleCnt_ff;
    busState_t   state_ff;

    // decode helper: direct address inside lower RAM
    function automatic logic isLower(input logic [7:0] a);
        return a <= `DM_LOWER_TOP;
    endfunction

    //------------------------------------------------------------------
    // internal RAM decode
    //------------------------------------------------------------------
    // direct split by address
    assign dirLower = isLower(dirAddr);
    assign sfrWr    = dirWr && !dirLower;
    // indirect and stack always use RAM
    assign iramWe    = (dirWr && dirLower) || (indWr && !(dirWr || dirRd));
    assign iramRe    = (dirRd && dirLower) || (indRd && !(dirWr || dirRd));
    assign iramAddr  = (dirWr || dirRd) ? dirAddr : indAddr;
    assign iramWdata = dirWr ? dirWdata : indWdata;
    assign indRdata  = iramQ;
    assign dirRdata  = dirFromRam_ff ? iramQ : sfrRd_ff;

    dmem_ram #(
        .DEPTH (IRAM_DEPTH),
        .AW    (8)
    ) u_iram (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .we      (iramWe),
        .re      (iramRe),
        .addr    (iramAddr),
        .wdata   (iramWdata),
        .rdata   (iramQ)
    );

    //------------------------------------------------------------------
    // control register bits
    //------------------------------------------------------------------
    // select bit written from bit 0, reset to first pointer
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pointerSelectBit_ff <= 1'b0;
        end
        else if (sfrWr && dirAddr == `DM_SFR_AUX1)
        begin
            pointerSelectBit_ff <= dirWdata[`DM_BIT_PSEL];
        end
    end

    // auxiliary control: external select and ALE suppression
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            externalRamSelect_ff <= 1'b0;
            aleOff_ff            <= 1'b0;
        end
        else if (sfrWr && dirAddr == `DM_SFR_AUX)
        begin
            externalRamSelect_ff <= dirWdata[`DM_BIT_EXTERNAL_RAM_SELECT];
            aleOff_ff            <= dirWdata[`DM_BIT_ALEOFF];
        end
    end

    // register read data, one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sfrRd_ff      <= `DM_RST_BYTE;
            dirFromRam_ff <= 1'b0;
        end
        else if (dirRd)
        begin
            dirFromRam_ff <= dirLower;
            sfrRd_ff      <= `DM_RST_BYTE;
            // flag bit and reserved bits read zero
            if (dirAddr == `DM_SFR_AUX1)
            begin
                sfrRd_ff[`DM_BIT_PSEL] <= pointerSelectBit_ff;
            end
            else if (dirAddr == `DM_SFR_AUX)
            begin
                sfrRd_ff[`DM_BIT_EXTERNAL_RAM_SELECT] <= externalRamSelect_ff;
                sfrRd_ff[`DM_BIT_ALEOFF] <= aleOff_ff;
            end
            else if (dirAddr == `DM_SFR_PTR_LO)
            begin
                sfrRd_ff <= curPtr[7:0];
            end
            else if (dirAddr == `DM_SFR_PTR_HI)
            begin
                sfrRd_ff <= curPtr[15:8];
            end
        end
    end

    //------------------------------------------------------------------
    // data pointers
    //------------------------------------------------------------------
    data_ptr_pair u_ptrs (
        .ref_clk          (ref_clk),
        .rst_n            (rst_n),
        .pointerSelectBit (pointerSelectBit_ff),
        .incEn            (ptrInc),
        .loadEn           (ptrLoad),
        .loadVal          (ptrImm),
        .wrLo             (sfrWr && dirAddr == `DM_SFR_PTR_LO),
        .wrHi             (sfrWr && dirAddr == `DM_SFR_PTR_HI),
        .byteData         (dirWdata),
        .curPtr           (curPtr)
    );

    // registered copy for code fetch and jumps
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ptrValue <= `DM_RST_WORD;
        end
        else
        begin
            ptrValue <= curPtr;
        end
    end

    //------------------------------------------------------------------
    // external move decode
    //------------------------------------------------------------------
    assign startMove = movxReq && state_ff == BUS_IDLE;
    assign moveAddr  = movxUsePtr ? curPtr : {8'h00, movxRiAddr};
    // onchip RAM only with select clear and low address
    assign toXram    = !externalRamSelect_ff && moveAddr <= `DM_EXPANDED_ONCHIP_RAM_TOP;
    assign xramWe    = startMove && toXram && movxWrite;
    assign xramRe    = startMove && toXram && !movxWrite;
    assign xramAddr  = moveAddr[8:0];

    dmem_ram #(
        .DEPTH (EXPANDED_ONCHIP_RAM_DEPTH),
        .AW    (9)
    ) u_expanded_onchip_ram (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .we      (xramWe),
        .re      (xramRe),
        .addr    (xramAddr),
        .wdata   (movxWdata),
        .rdata   (xramQ)
    );

    //------------------------------------------------------------------
    // external move sequencer
    //------------------------------------------------------------------
    // phases, pins and completion
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff  <= BUS_IDLE;
            cnt_ff    <= 4'h0;
            write_ff  <= 1'b0;
            usePtr_ff <= 1'b0;
            wdata_ff  <= `DM_RST_BYTE;
            p0Out     <= `DM_RST_BYTE;
            p0Oe      <= 1'b0;
            p2Out     <= `DM_RST_BYTE;
            p2Oe      <= 1'b0;
            wrStrobeN <= 1'b1;
            rdStrobeN <= 1'b1;
            movxDone  <= 1'b0;
            movxRdata <= `DM_RST_BYTE;
        end
        else
        begin
            movxDone <= 1'b0;
            unique case (state_ff)
                BUS_IDLE:
                begin
                    p2Oe <= 1'b0;
                    if (startMove)
                    begin
                        write_ff  <= movxWrite;
                        usePtr_ff <= movxUsePtr;
                        wdata_ff  <= movxWdata;
                        cnt_ff    <= 4'h0;
                        // port 2 carries pointer high byte
                        p2Out     <= moveAddr[15:8];
                        p2Oe      <= movxUsePtr;
                        if (toXram)
                        begin
                            state_ff <= BUS_EXPANDED_ONCHIP_RAM;
                        end
                        else
                        begin
                            p0Out    <= moveAddr[7:0];
                            p0Oe     <= 1'b1;
                            state_ff <= BUS_ADDR;
                        end
                    end
                end
                BUS_EXPANDED_ONCHIP_RAM:
                begin
                    movxRdata <= write_ff ? movxRdata : xramQ;
                    movxDone  <= 1'b1;
                    state_ff  <= BUS_IDLE;
                end
                BUS_ADDR:
                begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == `DM_ADDR_CYC - 4'h1)
                    begin
                        cnt_ff   <= 4'h0;
                        p0Out    <= wdata_ff;
                        p0Oe     <= write_ff;
                        wrStrobeN <= !write_ff;
                        rdStrobeN <= write_ff;
                        state_ff <= BUS_STROBE;
                    end
                end
                BUS_STROBE:
                begin
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == `DM_STROBE_CYC - 4'h1)
                    begin
                        wrStrobeN <= 1'b1;
                        rdStrobeN <= 1'b1;
                        p0Oe      <= 1'b0;
                        p2Oe      <= 1'b0;
                        movxRdata <= write_ff ? movxRdata : p0In;
                        movxDone  <= 1'b1;
                        state_ff  <= BUS_IDLE;
                    end
                end
                default:
                begin
                    state_ff <= BUS_IDLE;
                end
            endcase
        end
    end

    // busy and phase mirror the sequencer
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            movxBusy <= 1'b0;
            busPhase <= BUS_IDLE;
        end
        else
        begin
            movxBusy <= startMove || (state_ff != BUS_IDLE && !movxDone
                        && !(state_ff == BUS_EXPANDED_ONCHIP_RAM)
                        && !(state_ff == BUS_STROBE && cnt_ff == `DM_STROBE_CYC - 4'h1));
            busPhase <= startMove ? (toXram ? BUS_EXPANDED_ONCHIP_RAM : BUS_ADDR) : state_ff;
        end
    end

    // address latch enable: free running unless suppressed
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aleCnt_ff <= 3'h0;
            aleOut    <= 1'b0;
        end
        else
        begin
            aleCnt_ff <= (aleCnt_ff == `DM_ALE_DIV - 3'h1) ? 3'h0 : aleCnt_ff + 3'h1;
            if (startMove && !toXram)
            begin
                aleOut <= 1'b1;
            end
            else if (state_ff == BUS_IDLE && !aleOff_ff)
            begin
                aleOut <= aleCnt_ff == 3'h0;
            end
            else
            begin
                aleOut <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------
    // first pointer after reset
    chk_psel_reset: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> !pointerSelectBit_ff)
        else $error("pointer select not zero after reset");

    chk_uflag_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        dirRd && dirAddr == `DM_SFR_AUX1 |=> !dirRdata[`DM_BIT_UFLAG])
        else $error("general flag read as one");

    // increment adds one to selected pointer
    chk_ptr_inc: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ptrInc && !ptrLoad && !sfrWr |=> curPtr == $past(curPtr) + 16'h0001)
        else $error("pointer increment wrong");

    chk_ptr_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ptrLoad && !sfrWr |=> curPtr == $past(ptrImm))
        else $error("pointer load wrong");

    // direct upper access never writes RAM
    chk_dir_sfr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        dirWr && !isLower(dirAddr) |-> !iramWe)
        else $error("direct upper write reached RAM");

    chk_ind_ram: assert property (@(posedge ref_clk) disable iff (!rst_n)
        indWr && !dirWr && !dirRd |-> iramWe && iramAddr == indAddr)
        else $error("indirect write missed RAM");

    // onchip move keeps port 0 and strobes idle
    chk_expanded_onchip_ram_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        startMove && toXram |=> !p0Oe && wrStrobeN && rdStrobeN ##1 movxDone)
        else $error("onchip move disturbed bus");

    // select clear, high pointer goes external
    chk_ext_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        startMove && movxUsePtr && curPtr > `DM_EXPANDED_ONCHIP_RAM_TOP |=> state_ff == BUS_ADDR && p0Oe)
        else $error("high pointer move not external");

    // pointer move drives high byte on port 2
    chk_p2_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        startMove && movxUsePtr && !toXram |=> p2Oe && p2Out == $past(curPtr[15:8]))
        else $error("port 2 lacks pointer high byte");

    // external move strobes the right line
    chk_strobe_dir: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_ff == BUS_ADDR && cnt_ff == `DM_ADDR_CYC - 4'h1
        |=> (wrStrobeN != rdStrobeN) && (wrStrobeN == !write_ff) [*3] ##1 wrStrobeN && rdStrobeN)
        else $error("external strobe wrong");
endmodule
`default_nettype wire

/* File: verification/ext_mem_model.sv */
// external data memory model on the multiplexed address/data bus
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] p0Out,
    input  wire logic       p0Oe,
    input  wire logic [7:0] p2Out,
    input  wire logic       p2Oe,
    input  wire logic       wrStrobeN,
    input  wire logic       rdStrobeN,
    input  wire logic       aleOut,
    output var  logic [7:0] p0In
);
    logic [7:0]  mem [0:65535];
    logic [15:0] addrLat = 16'h0000;
    logic [7:0]  lastP0  = 8'h00;
    always_ff @(posedge ref_clk)
        if (aleOut && p0Oe)
            addrLat <= {p2Oe ? p2Out : 8'h00, p0Out};
    always_ff @(posedge ref_clk)
        if (!wrStrobeN)
            mem[addrLat] <= p0Out;
    // released bus toggles every cycle
    always_ff @(posedge ref_clk)
        lastP0 <= p0In;
    assign p0In = !rdStrobeN ? mem[addrLat] : ~lastP0;
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the data memory map block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import dmem_pkg::*;
    logic            ref_clk = 1'b0;
    logic            rst_n = 1'b0;
    logic [7:0]      dirAddr = 8'h00, dirWdata = 8'h00, indAddr = 8'h00, indWdata = 8'h00;
    logic            dirWr = 1'b0, dirRd = 1'b0, indWr = 1'b0, indRd = 1'b0;
    logic            ptrInc = 1'b0, ptrLoad = 1'b0, movxReq = 1'b0;
    logic            movxWrite = 1'b0, movxUsePtr = 1'b0;
    logic [15:0]     ptrImm = 16'h0000;
    logic [7:0]      movxRiAddr = 8'h00, movxWdata = 8'h00, q;
    logic [3:0]      s;
    logic            ext = 1'b0;
    wire logic [7:0] dirRdata, indRdata, movxRdata, p0In, p0Out, p2Out;
    wire logic [15:0] ptrValue;
    wire logic       movxBusy, movxDone, p0Oe, p2Oe, wrStrobeN, rdStrobeN, aleOut;
    busState_t       busPhase;
    int              fails = 0;
    int              tests_run = 0;
    // clock, 10 ns period
    always #5 ref_clk = ~ref_clk;
    dmem_map_core DUT (.ref_clk, .rst_n, .dirAddr, .dirWdata, .dirWr, .dirRd, .dirRdata,
        .indAddr, .indWdata, .indWr, .indRd, .indRdata, .ptrInc, .ptrLoad, .ptrImm,
        .ptrValue, .movxReq, .movxWrite, .movxUsePtr, .movxRiAddr, .movxWdata, .movxBusy,
        .movxDone, .movxRdata, .p0In, .p0Out, .p0Oe, .p2Out, .p2Oe, .wrStrobeN,
        .rdStrobeN, .aleOut, .busPhase);
    ext_mem_model mdl (.ref_clk, .p0Out, .p0Oe, .p2Out, .p2Oe, .wrStrobeN, .rdStrobeN,
        .aleOut, .p0In);
    //------------------------------------------------------------------
    // shared tasks
    //------------------------------------------------------------------
    task results();
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one register port cycle, direct or indirect
    task rw(input logic ind, input logic wr, input logic [7:0] a, input logic [7:0] d,
            output logic [7:0] r);
        @(posedge ref_clk);
        dirAddr <= a;
        indAddr <= a;
        dirWdata <= d;
        indWdata <= d;
        dirWr <= wr & !ind;
        dirRd <= !wr & !ind;
        indWr <= wr & ind;
        indRd <= !wr & ind;
        @(posedge ref_clk);
        {dirWr, dirRd, indWr, indRd} <= 4'h0;
        #1;
        r = ind ? indRdata : dirRdata;
    endtask
    task pop(input logic ld, input logic [15:0] v);
        @(posedge ref_clk);
        ptrLoad <= ld;
        ptrInc <= !ld;
        ptrImm <= v;
        @(posedge ref_clk);
        ptrLoad <= 1'b0;
        ptrInc <= 1'b0;
    endtask
    // external move; f = {port 2 driven, bus used, write seen, read seen}
    task mx(input logic wr, input logic up, input logic [7:0] ri, input logic [7:0] d,
            output logic [3:0] f, output logic [7:0] r);
        int i;
        f = 4'h0;
        @(posedge ref_clk);
        movxReq <= 1'b1;
        movxWrite <= wr;
        movxUsePtr <= up;
        movxRiAddr <= ri;
        movxWdata <= d;
        @(posedge ref_clk);
        movxReq <= 1'b0;
        for (i = 0; i < 20; i++)
        begin
            #1;
            f |= {p2Oe, p0Oe | !wrStrobeN | !rdStrobeN, !wrStrobeN, !rdStrobeN};
            if (i == 0)
            begin
                check(movxBusy, 1'b1);
                check(busPhase, ext ? BUS_ADDR : BUS_EXPANDED_ONCHIP_RAM);
            end
            if (movxDone === 1'b1)
                break;
            @(posedge ref_clk);
        end
        r = movxRdata;
        check(movxBusy, 1'b0);
        if (i == 20)
        begin
            fails++;
            $display("[ERR] %0t external move timed out", $time);
            results();
        end
    endtask
    //------------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------------
    task t_reset();
        rw(0, 0, 8'ha2, 8'h00, q);
        check(q, 8'h00);
        check(ptrValue, 16'h0000);
        $display("test reset done");
    endtask
    task t_ptr();
        pop(1, 16'h1234);
        rw(0, 1, 8'ha2, 8'hff, q);
        rw(0, 0, 8'ha2, 8'h00, q);
        check(q, 8'h01);
        pop(1, 16'hffff);
        pop(0, 16'h0000);
        rw(0, 0, 8'h82, 8'h00, q);
        check(q, 8'h00);
        rw(0, 0, 8'h83, 8'h00, q);
        check(q, 8'h00);
        rw(0, 1, 8'h83, 8'hab, q);
        rw(0, 0, 8'h83, 8'h00, q);
        check(q, 8'hab);
        rw(0, 1, 8'ha2, 8'h00, q);
        rw(0, 0, 8'h82, 8'h00, q);
        check(q, 8'h34);
        rw(0, 0, 8'h83, 8'h00, q);
        check(q, 8'h12);
        check(ptrValue, 16'h1234);
        $display("test pointers done");
    endtask
    task t_ram();
        rw(1, 1, 8'h10, 8'haa, q);
        rw(0, 0, 8'h10, 8'h00, q);
        check(q, 8'haa);
        rw(0, 1, 8'h11, 8'h5c, q);
        rw(1, 0, 8'h11, 8'h00, q);
        check(q, 8'h5c);
        rw(1, 1, 8'h82, 8'h99, q);
        rw(0, 0, 8'h82, 8'h00, q);
        check(q, 8'h34);
        rw(0, 1, 8'h82, 8'h66, q);
        rw(1, 0, 8'h82, 8'h00, q);
        check(q, 8'h99);
        rw(0, 0, 8'h82, 8'h00, q);
        check(q, 8'h66);
        $display("test ram done");
    endtask
    task t_expanded_onchip_ram();
        pop(1, 16'h01ff);
        mx(1, 1, 8'h00, 8'h3c, s, q);
        check(s, 4'h8);
        rw(1, 1, 8'h40, 8'h11, q);
        mx(1, 0, 8'h40, 8'h22, s, q);
        check(s, 4'h0);
        rw(1, 0, 8'h40, 8'h00, q);
        check(q, 8'h11);
        mx(0, 1, 8'h00, 8'h00, s, q);
        check(q, 8'h3c);
        mx(0, 0, 8'h40, 8'h00, s, q);
        check(q, 8'h22);
        $display("test onchip done");
    endtask
    task t_ext();
        ext = 1'b1;
        pop(1, 16'h0200);
        mx(1, 1, 8'h00, 8'h77, s, q);
        check(s, 4'he);
        check(mdl.mem[16'h0200], 8'h77);
        mx(0, 1, 8'h00, 8'h00, s, q);
        check(s, 4'hd);
        check(q, 8'h77);
        rw(0, 1, 8'h8e, 8'h02, q);
        mx(1, 0, 8'h40, 8'h5a, s, q);
        check(s, 4'h6);
        check(mdl.mem[16'h0040], 8'h5a);
        pop(1, 16'h01ff);
        mx(1, 1, 8'h00, 8'hc3, s, q);
        check(s, 4'he);
        check(mdl.mem[16'h01ff], 8'hc3);
        $display("test external done");
    endtask
    // address latch pulses: suppressed, then one in six idle cycles
    task t_ale();
        logic [3:0] n;
        n = 4'h0;
        rw(0, 1, 8'h8e, 8'h03, q);
        rw(0, 0, 8'h8e, 8'h00, q);
        check(q, 8'h03);
        repeat (12)
        begin
            @(posedge ref_clk);
            #1;
            n += aleOut;
        end
        check(n, 4'h0);
        rw(0, 1, 8'h8e, 8'h02, q);
        repeat (12)
        begin
            @(posedge ref_clk);
            #1;
            n += aleOut;
        end
        check(n, 4'h2);
        $display("test ale done");
    endtask
    // main sequence
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_ptr();
        t_ram();
        t_expanded_onchip_ram();
        t_ext();
        t_ale();
        results();
    end
endmodule
`default_nettype wire
